// >>> hdl/fcq_map.svh
`ifndef FCQ_MAP_SVH
`define FCQ_MAP_SVH

`define ADDR_W 24
`define DQ_W 16

// command codes, low byte only
`define CODE_READ_ARRAY 8'hFF
`define CODE_IDENT 8'h90
`define CODE_QUERY 8'h98
`define CODE_STATUS 8'h70
`define CODE_CLR_STATUS 8'h50
`define CODE_BUF_WRITE 8'hE8
`define CODE_PROGRAM 8'h40
`define CODE_ERASE 8'h20
`define CODE_SUSPEND 8'hB0
`define CODE_CONFIRM 8'hD0
`define CODE_LOCK_CFG 8'h60

// buffered-write count limits, status bit and query start address
`define BUF_MAX_BYTE 5'h1F
`define BUF_MAX_WORD 5'h0F
`define STATUS_READY_BIT 7
`define QUERY_START 24'h000010

// bus timing
`define CLK_MHZ 200
`define T_WP_NS 70
`define T_WR_NS 30
`define T_ACC_NS 150
`define T_SETTLE_NS 100
`define WP_CYC ((`T_WP_NS * `CLK_MHZ + 999) / 1000)
`define WR_CYC ((`T_WR_NS * `CLK_MHZ + 999) / 1000)
`define ACC_CYC ((`T_ACC_NS * `CLK_MHZ + 999) / 1000)
`define SETTLE_CYC ((`T_SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

// >>> hdl/fcq_pkg.sv
package fcq_pkg;
`include "fcq_map.svh"

	typedef enum logic [3:0] {
		OP_READ_ARRAY = 4'h0,
		OP_IDENT = 4'h1,
		OP_QUERY = 4'h2,
		OP_STATUS = 4'h3,
		OP_CLR_STATUS = 4'h4,
		OP_PROGRAM = 4'h5,
		OP_BUF_WRITE = 4'h6,
		OP_ERASE = 4'h7,
		OP_SUSPEND = 4'h8,
		OP_RESUME = 4'h9,
		OP_UNLOCK_ALL = 4'hA
	} op_type;

	typedef enum logic [2:0] {
		FSM_IDLE = 3'h0,
		FSM_WRITE = 3'h1,
		FSM_WREC = 3'h2,
		FSM_READ = 3'h3,
		FSM_NEXT = 3'h4,
		FSM_FETCH = 3'h5,
		FSM_BUSY = 3'h6
	} fsm_type;

	typedef enum logic [2:0] {
		PH_CODE = 3'h0,
		PH_XSR = 3'h1,
		PH_COUNT = 3'h2,
		PH_DATA = 3'h3,
		PH_SECOND = 3'h4,
		PH_READ = 3'h5
	} phase_type;

	typedef struct packed {
		op_type op;
		logic [`ADDR_W-1:0] addr;
		logic [`DQ_W-1:0] data;
		logic [4:0] count;
	} req_type;

	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic [`DQ_W-1:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic byte_n;
		logic program_enable_supply;
	} flash_out_type;

	typedef struct packed {
		fsm_type fsm;
		phase_type ph;
		op_type op;
		logic [7:0] cnt;
		logic [4:0] items;
		logic [`DQ_W-1:0] wdata;
		flash_out_type pins;
		logic req_ready;
		logic wdata_ready;
		logic done;
		logic [`DQ_W-1:0] rdata;
		logic [2:0] sync;
		logic sts_high;
	} state_type;

endpackage : fcq_pkg

// >>> hdl/flash_cmd_host.sv
`timescale 1ns/100ps
`include "fcq_map.svh"
module flash_cmd_host (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// configuration
	input wire logic byte_mode,
	// request port
	input wire fcq_pkg::req_type req,
	input wire logic req_valid,
	output logic req_ready,
	// buffered-write data stream
	input wire logic [`DQ_W-1:0] wdata,
	input wire logic wdata_valid,
	output logic wdata_ready,
	// answer
	output logic [`DQ_W-1:0] rsp_data,
	output logic rsp_done,
	// flash pins
	output fcq_pkg::flash_out_type flash_o,
	input wire logic [`DQ_W-1:0] dq_in,
	input wire logic status_pin
);

	fcq_pkg::state_type s_r;
	fcq_pkg::state_type s_nxt;

	function automatic logic [7:0] first_code(input fcq_pkg::op_type op);
		unique case (op)
			fcq_pkg::OP_READ_ARRAY: first_code = `CODE_READ_ARRAY;
			fcq_pkg::OP_IDENT: first_code = `CODE_IDENT;
			fcq_pkg::OP_QUERY: first_code = `CODE_QUERY;
			fcq_pkg::OP_STATUS: first_code = `CODE_STATUS;
			fcq_pkg::OP_CLR_STATUS: first_code = `CODE_CLR_STATUS;
			fcq_pkg::OP_PROGRAM: first_code = `CODE_PROGRAM;
			fcq_pkg::OP_BUF_WRITE: first_code = `CODE_BUF_WRITE;
			fcq_pkg::OP_ERASE: first_code = `CODE_ERASE;
			fcq_pkg::OP_SUSPEND: first_code = `CODE_SUSPEND;
			fcq_pkg::OP_RESUME: first_code = `CODE_CONFIRM;
			fcq_pkg::OP_UNLOCK_ALL: first_code = `CODE_LOCK_CFG;
			default: first_code = `CODE_READ_ARRAY;
		endcase
	endfunction : first_code

	function automatic fcq_pkg::state_type go_write(input fcq_pkg::state_type s,
		input logic [`DQ_W-1:0] d);
		go_write = s;
		go_write.fsm = fcq_pkg::FSM_WRITE;
		go_write.cnt = 8'(`WP_CYC);
		go_write.pins.dq_out = d;
		go_write.pins.dq_oe = 1'b1;
		go_write.pins.ce_n = 1'b0;
		go_write.pins.we_n = 1'b0;
	endfunction : go_write

	function automatic fcq_pkg::state_type go_cmd(input fcq_pkg::state_type s,
		input logic [7:0] code);
		go_cmd = go_write(s, {8'h00, code});
	endfunction : go_cmd

	function automatic fcq_pkg::state_type go_read(input fcq_pkg::state_type s);
		go_read = s;
		go_read.fsm = fcq_pkg::FSM_READ;
		go_read.cnt = 8'(`ACC_CYC);
		go_read.pins.ce_n = 1'b0;
		go_read.pins.oe_n = 1'b0;
	endfunction : go_read

	function automatic logic is_read_op(input fcq_pkg::op_type op);
		is_read_op = (op == fcq_pkg::OP_READ_ARRAY) || (op == fcq_pkg::OP_IDENT) ||
			(op == fcq_pkg::OP_QUERY) || (op == fcq_pkg::OP_STATUS);
	endfunction : is_read_op

	always_comb begin
		logic [4:0] lim;
		logic [`DQ_W-1:0] sample;
		s_nxt = s_r;
		lim = s_r.pins.byte_n ? `BUF_MAX_WORD : `BUF_MAX_BYTE;
		sample = dq_in;
		s_nxt.done = 1'b0;
		s_nxt.pins.byte_n = ~byte_mode;
		// stage 0 feeds only stage 1; level counts once stages 1 and 2 agree
		s_nxt.sync = {s_r.sync[1:0], status_pin};
		if (s_r.sync[1] == s_r.sync[2]) begin
			s_nxt.sts_high = s_r.sync[2];
		end
		if (s_r.cnt != 8'h00) begin
			s_nxt.cnt = s_r.cnt - 8'h01;
		end
		unique case (s_r.fsm)
			fcq_pkg::FSM_IDLE: begin
				if (req_valid && s_r.req_ready) begin
					s_nxt.req_ready = 1'b0;
					s_nxt.op = req.op;
					s_nxt.ph = fcq_pkg::PH_CODE;
					s_nxt.pins.addr = req.addr;
					s_nxt.wdata = req.data;
					s_nxt.items = (req.count > lim) ? lim : req.count;
					// supply raised for every operation except reads and clear status; reads do not need it
					s_nxt.pins.program_enable_supply = !is_read_op(req.op) &&
						(req.op != fcq_pkg::OP_CLR_STATUS);
					s_nxt = go_cmd(s_nxt, first_code(req.op));
				end
			end
			fcq_pkg::FSM_WRITE: begin
				if (s_r.cnt <= 8'h01) begin
					s_nxt.pins.we_n = 1'b1;
					s_nxt.fsm = fcq_pkg::FSM_WREC;
					s_nxt.cnt = 8'(`WR_CYC);
				end
			end
			fcq_pkg::FSM_WREC: begin
				// data and address stay driven after the strobe rises
				if (s_r.cnt <= 8'h01) begin
					s_nxt.pins.dq_oe = 1'b0;
					s_nxt.pins.ce_n = 1'b1;
					s_nxt.fsm = fcq_pkg::FSM_NEXT;
				end
			end
			fcq_pkg::FSM_READ: begin
				if (s_r.cnt <= 8'h01) begin
					s_nxt.pins.oe_n = 1'b1;
					s_nxt.pins.ce_n = 1'b1;
					s_nxt.fsm = fcq_pkg::FSM_NEXT;
					// busy status masks the floating bits in either bus width
					if (s_r.op == fcq_pkg::OP_STATUS && !s_r.sts_high) begin
						s_nxt.rdata = {8'h00, sample[7], 7'h00};
					end else if (s_r.op == fcq_pkg::OP_QUERY || !s_r.pins.byte_n) begin
						s_nxt.rdata = {8'h00, sample[7:0]};
					end else begin
						s_nxt.rdata = sample;
					end
				end
			end
			fcq_pkg::FSM_FETCH: begin
				if (wdata_valid && s_r.wdata_ready) begin
					s_nxt.wdata_ready = 1'b0;
					s_nxt = go_write(s_nxt, wdata);
				end
			end
			fcq_pkg::FSM_BUSY: begin
				// settle time lets the device pull the status pin low first
				if (s_r.cnt == 8'h00 && s_r.sts_high) begin
					s_nxt.fsm = fcq_pkg::FSM_IDLE;
					s_nxt.done = 1'b1;
					s_nxt.req_ready = 1'b1;
					s_nxt.pins.program_enable_supply = 1'b0;
				end
			end
			fcq_pkg::FSM_NEXT: begin
				unique case (s_r.ph)
					fcq_pkg::PH_CODE: begin
						if (is_read_op(s_r.op)) begin
							s_nxt.ph = fcq_pkg::PH_READ;
							s_nxt = go_read(s_nxt);
						end else if (s_r.op == fcq_pkg::OP_BUF_WRITE) begin
							s_nxt.ph = fcq_pkg::PH_XSR;
							s_nxt = go_read(s_nxt);
						end else if (s_r.op == fcq_pkg::OP_PROGRAM) begin
							s_nxt.ph = fcq_pkg::PH_SECOND;
							s_nxt = go_write(s_nxt, s_r.wdata);
						end else if (s_r.op == fcq_pkg::OP_ERASE ||
							s_r.op == fcq_pkg::OP_UNLOCK_ALL) begin
							s_nxt.ph = fcq_pkg::PH_SECOND;
							s_nxt = go_cmd(s_nxt, `CODE_CONFIRM);
						end else begin
							s_nxt.fsm = fcq_pkg::FSM_IDLE;
							s_nxt.done = 1'b1;
							s_nxt.req_ready = 1'b1;
							s_nxt.pins.program_enable_supply = 1'b0;
						end
					end
					fcq_pkg::PH_XSR: begin
						if (s_r.rdata[`STATUS_READY_BIT]) begin
							s_nxt.ph = fcq_pkg::PH_COUNT;
							s_nxt = go_write(s_nxt, {11'h000, s_r.items});
						end else begin
							s_nxt.ph = fcq_pkg::PH_CODE;
							s_nxt = go_cmd(s_nxt, `CODE_BUF_WRITE);
						end
					end
					fcq_pkg::PH_COUNT: begin
						s_nxt.ph = fcq_pkg::PH_DATA;
						s_nxt.fsm = fcq_pkg::FSM_FETCH;
						s_nxt.wdata_ready = 1'b1;
					end
					fcq_pkg::PH_DATA: begin
						if (s_r.items == 5'h00) begin
							s_nxt.ph = fcq_pkg::PH_SECOND;
							s_nxt = go_cmd(s_nxt, `CODE_CONFIRM);
						end else begin
							s_nxt.items = s_r.items - 5'h01;
							s_nxt.fsm = fcq_pkg::FSM_FETCH;
							s_nxt.wdata_ready = 1'b1;
						end
					end
					fcq_pkg::PH_SECOND: begin
						s_nxt.fsm = fcq_pkg::FSM_BUSY;
						s_nxt.cnt = 8'(`SETTLE_CYC);
					end
					fcq_pkg::PH_READ: begin
						s_nxt.fsm = fcq_pkg::FSM_IDLE;
						s_nxt.done = 1'b1;
						s_nxt.req_ready = 1'b1;
						s_nxt.pins.program_enable_supply = 1'b0;
					end
					default: begin
						s_nxt.fsm = fcq_pkg::FSM_IDLE;
						s_nxt.req_ready = 1'b1;
					end
				endcase
			end
			default: begin
				s_nxt.fsm = fcq_pkg::FSM_IDLE;
				s_nxt.req_ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.fsm <= fcq_pkg::FSM_IDLE;
			s_r.req_ready <= 1'b1;
			s_r.pins.ce_n <= 1'b1;
			s_r.pins.oe_n <= 1'b1;
			s_r.pins.we_n <= 1'b1;
			s_r.pins.byte_n <= 1'b1;
			s_r.sync <= 3'h7;
			s_r.sts_high <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign req_ready = s_r.req_ready;
	assign wdata_ready = s_r.wdata_ready;
	assign rsp_data = s_r.rdata;
	assign rsp_done = s_r.done;
	assign flash_o = s_r.pins;

endmodule : flash_cmd_host

// >>> verification/fcq_check_sva.sv
`timescale 1ns/100ps
module fcq_check (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// host side
	input wire logic byte_mode,
	input wire fcq_pkg::req_type req,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [15:0] rsp_data,
	input wire logic rsp_done,
	// flash side
	input wire fcq_pkg::flash_out_type flash_o,
	input wire logic status_pin
);
	localparam logic [7:0] CODE [0:10] = '{8'hFF, 8'h90, 8'h98, 8'h70, 8'h50, 8'h40,
		8'hE8, 8'h20, 8'hB0, 8'hD0, 8'h60};
	fcq_pkg::op_type op_r;
	logic [4:0] cnt_r;
	logic [5:0] nwr_r;
	logic [7:0] first_r;
	logic [7:0] last_r;
	logic we_r;
	wire logic [4:0] lim = byte_mode ? 5'h1F : 5'h0F;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// write strobes counted per operation, no reset needed: cleared at each take
	always_ff @(posedge clock) begin
		we_r <= flash_o.we_n;
		if (req_valid && req_ready) begin
			op_r <= req.op;
			cnt_r <= (req.count > lim) ? lim : req.count;
			nwr_r <= 6'h00;
		end else if (we_r && !flash_o.we_n) begin
			nwr_r <= nwr_r + 6'h01;
			last_r <= flash_o.dq_out[7:0];
			if (nwr_r == 6'h00)
				first_r <= flash_o.dq_out[7:0];
		end
	end
	property p_hold;
		$rose(flash_o.we_n) |-> (flash_o.dq_oe && $stable(flash_o.dq_out))[*6];
	endproperty
	a_hold: assert property (p_hold) else $error("write data not held");
	property p_supply;
		!flash_o.we_n && flash_o.dq_out[7:0] inside {8'h20, 8'h40, 8'hE8, 8'h60}
			|-> flash_o.program_enable_supply;
	endproperty
	a_supply: assert property (p_supply) else $error("supply low on alter");
	property p_array;
		!flash_o.we_n && op_r == fcq_pkg::OP_READ_ARRAY
			|-> !flash_o.program_enable_supply && flash_o.dq_out[7:0] == 8'hFF;
	endproperty
	a_array: assert property (p_array) else $error("read array code wrong");
	property p_first;
		rsp_done |-> first_r == CODE[op_r];
	endproperty
	a_first: assert property (p_first) else $error("wrong first code");
	property p_count;
		rsp_done && op_r == fcq_pkg::OP_BUF_WRITE |-> nwr_r == {1'b0, cnt_r} + 6'h04;
	endproperty
	a_count: assert property (p_count) else $error("buffer write count");
	property p_confirm;
		rsp_done && op_r inside {fcq_pkg::OP_BUF_WRITE, fcq_pkg::OP_ERASE,
			fcq_pkg::OP_UNLOCK_ALL} |-> last_r == 8'hD0;
	endproperty
	a_confirm: assert property (p_confirm) else $error("no confirm");
	property p_wait;
		rsp_done && op_r inside {fcq_pkg::OP_PROGRAM, fcq_pkg::OP_BUF_WRITE,
			fcq_pkg::OP_ERASE, fcq_pkg::OP_UNLOCK_ALL} |-> $past(status_pin, 3);
	endproperty
	a_wait: assert property (p_wait) else $error("done while busy");
	property p_query;
		rsp_done && (op_r == fcq_pkg::OP_QUERY || byte_mode && op_r == fcq_pkg::OP_READ_ARRAY)
			|-> rsp_data[15:8] == 8'h00;
	endproperty
	a_query: assert property (p_query) else $error("upper byte not zero");
	property p_reset;
		$fell(sys_rst) |-> req_ready && flash_o.ce_n && flash_o.we_n && !flash_o.dq_oe;
	endproperty
	a_reset: assert property (p_reset) else $error("not idle after reset");
	c_buf: cover property (rsp_done && op_r == fcq_pkg::OP_BUF_WRITE);
	c_query: cover property (rsp_done && op_r == fcq_pkg::OP_QUERY);
	c_x8: cover property (rsp_done && byte_mode);
endmodule : fcq_check

bind flash_cmd_host fcq_check u_fcq_check (.clock, .sys_rst, .byte_mode, .req, .req_valid,
	.req_ready, .rsp_data, .rsp_done, .flash_o, .status_pin);

// >>> verification/flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model (
	// flash pins
	input wire fcq_pkg::flash_out_type flash_o,
	output logic [15:0] dq_in,
	output logic status_pin,
	// scenario control
	input wire logic hold_busy
);
	parameter int BUSY_NS = 400;
	localparam logic [15:0] ID_WORD = 16'h00A7; // arbitrary value
	parameter logic [15:0] RCFG_DEFAULT = 16'h0000;
	logic [15:0] rcfg = RCFG_DEFAULT;
	int mode = 0;
	int st = 0;
	int left = 0;
	int nitem = 0;
	int starts = 0;
	logic [4:0] n;
	logic susp = 1'b0;
	logic fl = 1'b0;
	logic [7:0] c;
	logic [23:0] qa;
	wire logic bsy = hold_busy || left > 0;
	// undriven lines toggle so a stale value never reads as valid
	always #5 fl = ~fl;
	always #10
		if (left > 0 && !susp)
			left--;
	assign status_pin = !bsy || susp;
	task automatic begin_work;
		left = BUSY_NS / 10;
		starts++;
		st = 0;
		mode = 3;
	endtask : begin_work
	always @(posedge flash_o.we_n) begin
		c = flash_o.dq_out[7:0];
		case (st)
		0: if (!(bsy && !susp) || c inside {8'h70, 8'hB0}) case (c)
			8'hFF: mode = 0;
			8'h90: mode = 1;
			8'h98: mode = 2;
			8'h70: mode = 3;
			8'hE8: {mode, st} = {32'd4, 32'd3};
			8'h40, 8'h10: st = 1;
			8'h20, 8'h60: st = 2;
			8'hB0: {susp, mode} = {bsy, 32'd3};
			8'hD0: susp = 1'b0;
			default: ;
		endcase
		1: begin_work();
		2: if (c == 8'hD0)
				begin_work();
			else
				{rcfg, st} = {flash_o.addr[16:1], 32'd0};
		3: {n, nitem, st} = {flash_o.dq_out[4:0], 32'd0, 32'd4};
		4: begin
			nitem++;
			if (nitem == n + 1)
				st = 5;
		end
		default: if (c == 8'hD0)
				begin_work();
			else
				{st, mode} = {32'd0, 32'd3};
		endcase
	end
	always_comb begin
		qa = flash_o.byte_n ? flash_o.addr : flash_o.addr >> 1;
		case (mode)
		0: dq_in = flash_o.addr[15:0] ^ 16'h3C5A;
		1: dq_in = ID_WORD;
		2: case (qa[7:0])
			8'h10: dq_in = 16'h0051;
			8'h11: dq_in = 16'h0052;
			8'h12: dq_in = 16'h0059;
			8'h13: dq_in = 16'h0001;
			default: dq_in = 16'h0000;
		endcase
		3: dq_in = bsy && !susp ? {{8{fl}}, 1'b0, {7{fl}}} : 16'h0080;
		default: dq_in = 16'h0080;
		endcase
		if (!flash_o.byte_n)
			dq_in[15:8] = {8{fl}};
		if (flash_o.ce_n || flash_o.oe_n)
			dq_in = {16{fl}};
	end
endmodule : flash_dev_model

// >>> verification/flash_cmd_host_test.sv
`timescale 1ns/100ps
module flash_cmd_host_test;
	logic clock;
	logic sys_rst;
	logic byte_mode;
	fcq_pkg::req_type req;
	logic req_valid;
	logic req_ready;
	logic [15:0] wdata;
	logic wdata_valid;
	logic wdata_ready;
	logic [15:0] rsp_data;
	logic rsp_done;
	fcq_pkg::flash_out_type flash_o;
	logic [15:0] dq_in;
	logic status_pin;
	logic hold_busy;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	flash_cmd_host u_flash_cmd_host (.clock, .sys_rst, .byte_mode, .req, .req_valid, .req_ready,
		.wdata, .wdata_valid, .wdata_ready, .rsp_data, .rsp_done, .flash_o, .dq_in, .status_pin);
	flash_dev_model u_flash_dev_model (.flash_o, .dq_in, .status_pin, .hold_busy);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	task automatic do_op(input fcq_pkg::op_type op, input logic [23:0] a, input logic [4:0] n);
		@(posedge clock);
		req <= '{op, a, 16'h1234, n};
		req_valid <= 1'b1;
		@(posedge clock);
		req_valid <= 1'b0;
		repeat (5000) begin
			@(negedge clock);
			if (rsp_done === 1'b1)
				break;
		end
	endtask : do_op
	task automatic t_array;
		do_op(fcq_pkg::OP_READ_ARRAY, 24'h000005, 5'h00);
		check("array", rsp_data, 16'h3C5F);
		do_op(fcq_pkg::OP_IDENT, 24'h000000, 5'h00);
		check("ident", rsp_data, u_flash_dev_model.ID_WORD);
		$display("array test done");
	endtask : t_array
	task automatic t_query;
		logic [7:0] q [0:4] = '{8'h51, 8'h52, 8'h59, 8'h01, 8'h00};
		for (int i = 0; i < 5; i++) begin
			do_op(fcq_pkg::OP_QUERY, 24'h000010 + i, 5'h00);
			check("query x16", rsp_data, {8'h00, q[i]});
		end
		@(posedge clock);
		byte_mode <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			do_op(fcq_pkg::OP_QUERY, 24'h000020 + i, 5'h00);
			check("query x8", rsp_data, {8'h00, q[i / 2]});
		end
		$display("query test done");
	endtask : t_query
	task automatic t_alter;
		logic [4:0] cnt [0:3] = '{5'h03, 5'h1F, 5'h1F, 5'h00};
		int items [0:3] = '{4, 16, 32, 1};
		int s = u_flash_dev_model.starts;
		do_op(fcq_pkg::OP_PROGRAM, 24'h000100, 5'h00);
		do_op(fcq_pkg::OP_ERASE, 24'h000200, 5'h00);
		do_op(fcq_pkg::OP_UNLOCK_ALL, 24'h000000, 5'h00);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			byte_mode <= i[1];
			do_op(fcq_pkg::OP_BUF_WRITE, 24'h000400, cnt[i]);
			check("buffer items", u_flash_dev_model.nitem, items[i]);
		end
		check("work starts", u_flash_dev_model.starts, s + 7);
		$display("alter test done");
	endtask : t_alter
	task automatic t_busy;
		logic [15:0] exp [0:2] = '{16'h0000, 16'h0080, 16'h0000};
		fcq_pkg::op_type ops [0:2] = '{fcq_pkg::OP_CLR_STATUS, fcq_pkg::OP_SUSPEND,
			fcq_pkg::OP_RESUME};
		@(posedge clock);
		hold_busy <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			do_op(ops[i], 24'h000000, 5'h00);
			do_op(fcq_pkg::OP_STATUS, 24'h000000, 5'h00);
			check("busy status", rsp_data, exp[i]);
		end
		@(posedge clock);
		hold_busy <= 1'b0;
		do_op(fcq_pkg::OP_STATUS, 24'h000000, 5'h00);
		check("idle status", rsp_data, 16'h0080);
		$display("busy test done");
	endtask : t_busy
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// buffer items step so each one is distinct on the wire
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (wdata_ready && wdata_valid)
			wdata <= wdata + 16'h0101;
		if (cyc == 40000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		sys_rst = 1'b1;
		byte_mode = 1'b0;
		req = '0;
		req_valid = 1'b0;
		wdata = 16'h0000;
		wdata_valid = 1'b1;
		hold_busy = 1'b0;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		t_array();
		t_query();
		t_alter();
		t_busy();
		final_report();
	end
endmodule : flash_cmd_host_test
